/* File: logic/cpw_pkg.sv */
// Package for the cascaded pulse generator / warm-up timer.
// Assumes a 32-bit AXI4-Lite register bus and one 40 MHz clock.
package cpw_pkg;
	// Bus geometry
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	// Register byte addresses
	localparam logic [ADDR_W-1:0] ADDR_LOWER_CTL = 5'h00;
	localparam logic [ADDR_W-1:0] ADDR_UPPER_CTL = 5'h04;
	localparam logic [ADDR_W-1:0] ADDR_PERIOD_LO = 5'h08;
	localparam logic [ADDR_W-1:0] ADDR_PERIOD_HI = 5'h0c;
	localparam logic [ADDR_W-1:0] ADDR_WIDTH_LO = 5'h10;
	localparam logic [ADDR_W-1:0] ADDR_WIDTH_HI = 5'h14;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h18;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Upper control fields
	localparam int UCTL_TFF_BIT = 7;
	localparam int UCTL_RUN_BIT = 3;
	localparam int UCTL_MODE_LSB = 0;
	localparam int MODE_W = 3;
	// Lower control fields
	localparam int LCTL_SRC_LSB = 4;
	localparam int SRC_W = 3;
	localparam int LCTL_CASC_LSB = 0;
	localparam int CASC_W = 2;
	localparam logic [CASC_W-1:0] CASC_16BIT = 2'h3;
	// Status fields
	localparam int STAT_FF_BIT = 16;
	localparam int STAT_RUN_BIT = 17;
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic RST_FF = 1'b0;
	// Timing figures of the warm-up mode with the slow source
	localparam int SLOW_SRC_HZ = 32768;
	localparam real WARM_MIN_MS = 7.81;
	localparam logic [15:0] WARM_MIN_PERIOD = 16'h0100;
	localparam int WARM_MIN_TICKS = int'(WARM_MIN_PERIOD);

	// Counter modes of the upper control register
	typedef enum logic [MODE_W-1:0] {
		CPW_MODE_WARMUP = 3'b101,
		CPW_MODE_PPG = 3'b111
	} cpw_mode_t;

	// Source selections of the lower control register
	typedef enum logic [SRC_W-1:0] {
		CPW_SRC_SLOW = 3'b100,
		CPW_SRC_EXT = 3'b111
	} cpw_src_t;
endpackage

/* File: logic/cpw_tick_select.sv */
// Count-tick selection for the cascaded timer.
// Assumes fast_tick and slow_tick are one-cycle pulses from the divider chain.
`timescale 1ns/10ps
`default_nettype none
module cpw_tick_select (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Selection
	input wire logic [cpw_pkg::SRC_W-1:0] src_sel,
	// Tick sources
	input wire logic fast_tick,
	input wire logic slow_tick,
	input wire logic counter_input_pin,
	// Selected tick
	output logic tick
);
	logic pin_meta;
	logic pin_sync;
	logic pin_prev;
	logic pin_fall;

	// Two-stage sampler; pin_meta feeds only pin_sync
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_meta <= 1'b1;
			pin_sync <= 1'b1;
			pin_prev <= 1'b1;
		end else begin
			pin_meta <= counter_input_pin;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// Falling edge advances the count
	assign pin_fall = pin_prev & ~pin_sync;

	// Registered tick, one cycle per source event
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick <= 1'b0;
		end else begin
			case (src_sel)
				cpw_pkg::CPW_SRC_EXT: begin
					tick <= pin_fall;
				end
				cpw_pkg::CPW_SRC_SLOW: begin
					tick <= slow_tick;
				end
				default: begin
					tick <= fast_tick;
				end
			endcase
		end
	end
endmodule // cpw_tick_select
`default_nettype wire

/* File: logic/cpw_timer.sv */
// Cascaded 16-bit pulse generator and warm-up counter with AXI4-Lite registers.
// Assumes an external divider supplies fast and slow ticks and an interrupt
// controller latches the single-cycle request.
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module cpw_timer (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [cpw_pkg::ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	// AXI4-Lite write data
	input wire logic [cpw_pkg::DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read address
	input wire logic [cpw_pkg::ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	// AXI4-Lite read data
	output logic [cpw_pkg::DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Tick sources
	input wire logic fast_tick,
	input wire logic slow_tick,
	input wire logic counter_input_pin,
	// Timer outputs
	output logic pulse_output_pin,
	output logic output_flipflop,
	output logic upper_timer_interrupt
);
	logic [7:0] lower_timer_control;
	logic [7:0] upper_timer_control;
	logic [7:0] period_compare_low;
	logic [7:0] period_compare_high;
	logic [7:0] width_compare_low;
	logic [7:0] width_compare_high;
	logic [15:0] count;
	logic [cpw_pkg::ADDR_W-1:0] wr_addr;
	logic [7:0] wr_byte;
	logic wr_lane0;
	logic aw_held;
	logic w_held;
	logic do_write;
	logic ctl_write;
	logic tick;
	logic running;
	logic mode_ppg;
	logic mode_warm;
	logic [15:0] inc;
	logic [15:0] period;
	logic [15:0] width;
	logic period_hit;
	logic width_hit;
	logic next_ff;
	logic [cpw_pkg::DATA_W-1:0] next_rdata;
	logic rd_ok;
	logic wr_ok;

	// Tick selection and pin edge detection
	cpw_tick_select u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.src_sel(lower_timer_control[cpw_pkg::LCTL_SRC_LSB +: cpw_pkg::SRC_W]),
		.fast_tick(fast_tick),
		.slow_tick(slow_tick),
		.counter_input_pin(counter_input_pin),
		.tick(tick)
	);

	// Write address and data are taken independently, in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			awready <= 1'b1;
			wready <= 1'b1;
			wr_addr <= '0;
			wr_byte <= cpw_pkg::RST_BYTE;
			wr_lane0 <= 1'b0;
		end else if (do_write) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
		end else begin
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				awready <= 1'b0;
				wr_addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_held <= 1'b1;
				wready <= 1'b0;
				wr_byte <= wdata[7:0];
				wr_lane0 <= wstrb[0];
			end
		end
		// Channels reopen only once the response is accepted
		if (aresetn && bvalid && bready) begin
			awready <= 1'b1;
			wready <= 1'b1;
		end
	end

	assign do_write = aw_held && w_held && !bvalid;
	assign wr_ok = wr_addr == cpw_pkg::ADDR_LOWER_CTL || wr_addr == cpw_pkg::ADDR_UPPER_CTL
		|| wr_addr == cpw_pkg::ADDR_PERIOD_LO || wr_addr == cpw_pkg::ADDR_PERIOD_HI
		|| wr_addr == cpw_pkg::ADDR_WIDTH_LO || wr_addr == cpw_pkg::ADDR_WIDTH_HI
		|| wr_addr == cpw_pkg::ADDR_STATUS;
	assign ctl_write = do_write && wr_lane0 && wr_addr == cpw_pkg::ADDR_UPPER_CTL;

	// Write response; status is read-only but answers OKAY
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= cpw_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp <= wr_ok ? cpw_pkg::RESP_OKAY : cpw_pkg::RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// Register stores; byte lane 0 carries all 8-bit fields
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lower_timer_control <= cpw_pkg::RST_BYTE;
			upper_timer_control <= cpw_pkg::RST_BYTE;
			period_compare_low <= cpw_pkg::RST_BYTE;
			period_compare_high <= cpw_pkg::RST_BYTE;
			width_compare_low <= cpw_pkg::RST_BYTE;
			width_compare_high <= cpw_pkg::RST_BYTE;
		end else if (do_write && wr_lane0) begin
			case (wr_addr)
				cpw_pkg::ADDR_LOWER_CTL: lower_timer_control <= wr_byte;
				cpw_pkg::ADDR_UPPER_CTL: upper_timer_control <= wr_byte;
				cpw_pkg::ADDR_PERIOD_LO: period_compare_low <= wr_byte;
				cpw_pkg::ADDR_PERIOD_HI: period_compare_high <= wr_byte;
				cpw_pkg::ADDR_WIDTH_LO: width_compare_low <= wr_byte;
				cpw_pkg::ADDR_WIDTH_HI: width_compare_high <= wr_byte;
				default: begin
				end
			endcase
		end
	end

	// Mode decode; one warm-up code serves every source; only the tick rate differs
	assign mode_ppg = upper_timer_control[cpw_pkg::UCTL_MODE_LSB +: cpw_pkg::MODE_W] == cpw_pkg::CPW_MODE_PPG;
	assign mode_warm = upper_timer_control[cpw_pkg::UCTL_MODE_LSB +: cpw_pkg::MODE_W]
		== cpw_pkg::CPW_MODE_WARMUP;
	assign running = upper_timer_control[cpw_pkg::UCTL_RUN_BIT] && (mode_ppg || mode_warm)
		&& lower_timer_control[cpw_pkg::LCTL_CASC_LSB +: cpw_pkg::CASC_W] == cpw_pkg::CASC_16BIT;

	// Compares read the live registers, so new values bite at once
	assign period = {period_compare_high, period_compare_low};
	assign width = {width_compare_high, width_compare_low};
	assign inc = count + 16'h0001;
	assign period_hit = mode_warm ? (inc[15:8] == period[15:8]) : (inc == period);
	assign width_hit = mode_ppg && inc == width;

	// Cascaded counter; a stopped counter sits at zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= cpw_pkg::RST_COUNT;
		end else if (!running) begin
			count <= cpw_pkg::RST_COUNT;
		end else if (tick) begin
			count <= period_hit ? cpw_pkg::RST_COUNT : inc;
		end
	end

	// Next flip-flop level; loads only while stopped before and after the write
	always_comb begin
		next_ff = output_flipflop;
		if (running && tick && mode_ppg) begin
			next_ff = output_flipflop ^ width_hit ^ period_hit;
		end else if (ctl_write && !running && !wr_byte[cpw_pkg::UCTL_RUN_BIT]) begin
			next_ff = wr_byte[cpw_pkg::UCTL_TFF_BIT];
		end
	end

	// Flip-flop and its inverted pin move together, both registered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			output_flipflop <= cpw_pkg::RST_FF;
			pulse_output_pin <= ~cpw_pkg::RST_FF;
		end else begin
			output_flipflop <= next_ff;
			pulse_output_pin <= ~next_ff;
		end
	end

	// One-cycle request per period match
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			upper_timer_interrupt <= 1'b0;
		end else begin
			upper_timer_interrupt <= running && tick && period_hit;
		end
	end

	// Read mux; unmapped addresses read zero with SLVERR
	always_comb begin
		next_rdata = '0;
		rd_ok = 1'b1;
		case (araddr)
			cpw_pkg::ADDR_LOWER_CTL: next_rdata[7:0] = lower_timer_control;
			cpw_pkg::ADDR_UPPER_CTL: next_rdata[7:0] = upper_timer_control;
			cpw_pkg::ADDR_PERIOD_LO: next_rdata[7:0] = period_compare_low;
			cpw_pkg::ADDR_PERIOD_HI: next_rdata[7:0] = period_compare_high;
			cpw_pkg::ADDR_WIDTH_LO: next_rdata[7:0] = width_compare_low;
			cpw_pkg::ADDR_WIDTH_HI: next_rdata[7:0] = width_compare_high;
			cpw_pkg::ADDR_STATUS: begin
				next_rdata[15:0] = count;
				next_rdata[cpw_pkg::STAT_FF_BIT] = output_flipflop;
				next_rdata[cpw_pkg::STAT_RUN_BIT] = running;
			end
			default: rd_ok = 1'b0;
		endcase
	end

	// Read channel: answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= cpw_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= next_rdata;
			rresp <= rd_ok ? cpw_pkg::RESP_OKAY : cpw_pkg::RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// Checks
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_pin_inverse: assert property (pulse_output_pin == ~output_flipflop)
		else $error("pulse pin not inverse of flip-flop");
	a_period_clear: assert property (running && tick && mode_ppg && inc == period
		|=> upper_timer_interrupt && count == 16'h0000)
		else $error("period match did not clear and interrupt");
	a_width_toggle: assert property (running && tick && mode_ppg && width_hit && !period_hit
		|=> output_flipflop != $past(output_flipflop) && count == $past(inc))
		else $error("width match did not toggle or counter cleared");
	a_warm_upper: assert property (running && tick && mode_warm && inc[15:8] == period[15:8]
		|=> upper_timer_interrupt && count == 16'h0000)
		else $error("warm-up upper byte match missed");
	a_warm_no_early: assert property (running && tick && mode_warm && inc[15:8] != period[15:8]
		|=> !upper_timer_interrupt && count == $past(inc))
		else $error("warm-up matched too early");
	a_irq_single: assert property (upper_timer_interrupt |=> !upper_timer_interrupt)
		else $error("interrupt longer than one cycle");
	a_count_hold: assert property (running && !tick |=> count == $past(count))
		else $error("counter moved without a tick");
	a_stop_clear: assert property (!running |=> count == 16'h0000)
		else $error("stopped counter not at zero");
	a_stop_hold: assert property (running && ctl_write |=> output_flipflop == $past(output_flipflop)
		|| $past(tick))
		else $error("flip-flop loaded by the stopping write");
	a_load_init: assert property (ctl_write && !running && !wr_byte[cpw_pkg::UCTL_RUN_BIT]
		|=> output_flipflop == $past(wr_byte[cpw_pkg::UCTL_TFF_BIT]) ##1 pulse_output_pin == !output_flipflop)
		else $error("initial value not loaded while stopped");
	a_warm_steady: assert property (running && mode_warm |=> $stable(output_flipflop))
		else $error("flip-flop moved in warm-up mode");

	c_ppg_period: cover property (running && mode_ppg && upper_timer_interrupt);
	c_warm_done: cover property (running && mode_warm && upper_timer_interrupt);
	c_width_then_period: cover property (width_hit && tick && running ##[1:300] upper_timer_interrupt);
	c_stopped_load: cover property (ctl_write && !running);
endmodule // cpw_timer
`default_nettype wire

/* File: dv/cpw_pin_model.sv */
// External count-clock source for the cascaded timer's input pin.
// Assumes the bench enables it only while the pin source is selected.
`timescale 1ns/10ps
`default_nettype none
module cpw_pin_model #(
	parameter int HALF = 3
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bench control
	input wire logic en,
	// Count clock toward the timer
	output logic counter_input_pin
);
	logic [3:0] hold;

	// Each level lasts HALF system cycles; idle stands high, no stray edges
	always_ff @(posedge aclk) begin
		if (!aresetn || !en) begin
			counter_input_pin <= 1'b1;
			hold <= 4'h0;
		end else if (hold == 4'(HALF - 1)) begin
			counter_input_pin <= ~counter_input_pin;
			hold <= 4'h0;
		end else begin
			hold <= hold + 4'h1;
		end
	end
endmodule // cpw_pin_model
`default_nettype wire

/* File: dv/cpw_timer_tb.sv */
// Self-checking bench for the cascaded pulse / warm-up timer.
// Assumes the pin model is compiled first; the bench stands in for the tick divider.
`timescale 1ns/10ps
`default_nettype none
module cpw_timer_tb;
	localparam int LIMIT = 40000;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, fast_tick, slow_tick, pin_en, irq_d;
	logic [4:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid, pin, pulse, ff, irq;
	logic [7:0] tcnt;
	logic [15:0] wv, pv;
	logic [33:0] exp_q[$];
	int err_total = 0;
	int comparisons = 0;
	int cyc, n;

	cpw_timer u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .fast_tick(fast_tick),
		.slow_tick(slow_tick), .counter_input_pin(pin), .pulse_output_pin(pulse), .output_flipflop(ff),
		.upper_timer_interrupt(irq));
	cpw_pin_model u_pin (.aclk(aclk), .aresetn(aresetn), .en(pin_en), .counter_input_pin(pin));

	// Clock
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic close_out();
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Write one byte register; address and data released separately when taken
	// No cycle count assumed; only the hang guard ends a stuck wait
	task automatic axw(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er = cpw_pkg::RESP_OKAY);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", {32'h0, er}, {32'h0, bresp});
	endtask

	// Read; the expected response and data go into the note queue
	task automatic axr(input logic [4:0] a, input logic [33:0] e);
		exp_q.push_back(e);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
	endtask

	task automatic wait_irq(output int k);
		k = 0;
		do begin
			@(negedge aclk);
			k++;
		end while (irq !== 1'b1 && k < 5000);
	endtask

	task automatic wait_ff(input logic v);
		int k;
		k = 0;
		while (ff !== v && k < 5000) begin
			@(negedge aclk);
			k++;
		end
	endtask

	// Length of the next run of the flip-flop at level v
	task automatic run_of(input logic v, output int k);
		wait_ff(v);
		k = 0;
		while (ff === v && k < 5000) begin
			@(negedge aclk);
			k++;
		end
	endtask

	// Divider stand-in: fast tick every 4 cycles, slow every 8; slow oscillator taken as running
	always @(posedge aclk) begin
		if (!aresetn) begin
			tcnt <= 8'h00;
			fast_tick <= 1'b0;
			slow_tick <= 1'b0;
		end else begin
			tcnt <= tcnt + 8'h01;
			fast_tick <= (tcnt[1:0] == 2'h3);
			slow_tick <= (tcnt[2:0] == 3'h7);
		end
	end

	// Read answers against the oldest note
	always @(posedge aclk) begin
		if (rvalid && rready) begin
			if (exp_q.size() == 0) begin
				chk("read unexpected", 34'h0, 34'h3ffffffff);
			end else begin
				chk("read", exp_q.pop_front(), {rresp, rdata});
			end
		end
	end

	// Pin is the inverse of the flip-flop; request lasts one cycle
	always @(negedge aclk) begin
		irq_d <= irq;
		if (aresetn) begin
			chk("pin", {33'h0, ~ff}, {33'h0, pulse});
			if (irq_d === 1'b1) chk("irq width", 34'h0, {33'h0, irq});
		end
	end

	// Hang guard
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			err_total++;
			close_out();
		end
	end

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, pin_en} <= 7'h00;
		{awaddr, araddr, wdata, wstrb} <= '0;
		void'($urandom(4973));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk("reset out", 34'h1, {32'h0, ff, pulse});
		axr(cpw_pkg::ADDR_STATUS, 34'h0);
		// Pulse generation with random compares across the byte boundary
		wv = 16'h00f0 + 16'($urandom_range(15, 0));
		pv = 16'h0108 + 16'($urandom_range(15, 0));
		axw(cpw_pkg::ADDR_WIDTH_LO, wv[7:0]);
		axw(cpw_pkg::ADDR_WIDTH_HI, wv[15:8]);
		axw(cpw_pkg::ADDR_PERIOD_LO, pv[7:0]);
		axw(cpw_pkg::ADDR_PERIOD_HI, pv[15:8]);
		axr(cpw_pkg::ADDR_WIDTH_LO, {26'h0, wv[7:0]});
		axr(cpw_pkg::ADDR_PERIOD_HI, {26'h0, pv[15:8]});
		axr(5'h1c, {cpw_pkg::RESP_SLVERR, 32'h0});
		axw(5'h1c, 8'h5a, cpw_pkg::RESP_SLVERR);
		axw(cpw_pkg::ADDR_LOWER_CTL, 8'h33);
		axw(cpw_pkg::ADDR_UPPER_CTL, 8'h57);
		axw(cpw_pkg::ADDR_UPPER_CTL, 8'h5f);
		wait_irq(n);
		wait_irq(n);
		chk("period", {16'h0, pv, 2'h0}, 34'(n));
		run_of(1'b1, n);
		chk("width", {16'h0, pv - wv, 2'h0}, 34'(n));
		// Stop mid-pulse: level held, later write loads the start level
		wait_ff(1'b1);
		axw(cpw_pkg::ADDR_UPPER_CTL, 8'h57);
		repeat (40) @(negedge aclk);
		chk("held", 34'h2, {32'h0, ff, pulse});
		axr(cpw_pkg::ADDR_STATUS, 34'h000010000);
		axw(cpw_pkg::ADDR_UPPER_CTL, 8'h57);
		@(negedge aclk);
		chk("load low", 34'h1, {32'h0, ff, pulse});
		axw(cpw_pkg::ADDR_UPPER_CTL, 8'hd7);
		@(negedge aclk);
		chk("load high", 34'h2, {32'h0, ff, pulse});
		axw(cpw_pkg::ADDR_UPPER_CTL, 8'h57);
		// External pin clock, one count per falling edge
		axw(cpw_pkg::ADDR_WIDTH_LO, 8'h02);
		axw(cpw_pkg::ADDR_WIDTH_HI, 8'h00);
		axw(cpw_pkg::ADDR_PERIOD_LO, 8'h05);
		axw(cpw_pkg::ADDR_PERIOD_HI, 8'h00);
		axw(cpw_pkg::ADDR_LOWER_CTL, 8'h73);
		pin_en <= 1'b1;
		axw(cpw_pkg::ADDR_UPPER_CTL, 8'h5f);
		wait_irq(n);
		wait_irq(n);
		chk("pin period", 34'd30, 34'(n));
		run_of(1'b1, n);
		chk("pin width", 34'd18, 34'(n));
		axw(cpw_pkg::ADDR_UPPER_CTL, 8'h57);
		axw(cpw_pkg::ADDR_UPPER_CTL, 8'h57);
		// Undecoded mode with run set must not count, even with pin edges arriving
		axw(cpw_pkg::ADDR_UPPER_CTL, 8'h0e);
		axr(cpw_pkg::ADDR_STATUS, 34'h0);
		pin_en <= 1'b0;
		// Warm-up on slow then fast source; low period byte must be ignored
		axw(cpw_pkg::ADDR_PERIOD_LO, 8'hab);
		axw(cpw_pkg::ADDR_PERIOD_HI, 8'h01);
		for (int i = 0; i < 2; i++) begin
			axw(cpw_pkg::ADDR_LOWER_CTL, (i == 0) ? 8'h43 : 8'h63);
			axw(cpw_pkg::ADDR_UPPER_CTL, 8'h05);
			axw(cpw_pkg::ADDR_UPPER_CTL, 8'h0d);
			wait_irq(n);
			wait_irq(n);
			chk("warm-up", (i == 0) ? 34'd2048 : 34'd1024, 34'(n));
			chk("warm-up out", 34'h1, {32'h0, ff, pulse});
			axw(cpw_pkg::ADDR_UPPER_CTL, 8'h05);
		end
		close_out();
	end
endmodule // cpw_timer_tb
`default_nettype wire
